// ===== src/secif_pkg.sv
// ----------------------------------------------------------------
// serial eeprom command interface: shared types and constants
// ----------------------------------------------------------------
// assumes a single 250 mhz core clock; pins arrive asynchronous
package secif_pkg;

	// serial pins of the three-wire link plus organisation strap
	typedef struct packed {
		logic cs;
		logic sclk;
		logic di;
		logic organization_select;
	} secif_pins_t;

	// two-bit opcodes after the start marker bit
	localparam logic [1:0] OP_EXT   = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;

	// extended command selected by the top two address-field bits
	localparam logic [1:0] EXT_DIS       = 2'h0;
	localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
	localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
	localparam logic [1:0] EXT_EN        = 2'h3;

	// address field width in word-wide mode; byte-wide adds one
	localparam int AFIELD_1K   = 6;
	localparam int AFIELD_2K4K = 8;
	localparam int BYTES_PER_KBIT = 128;
	localparam logic [4:0] OPC_LAST = 5'h01;

	// self-timed programming, typical figures
	localparam int CLK_PERIOD_NS = 4;
	localparam int TWC_TYP_MS    = 4;
	localparam int TEC_TYP_MS    = 8;
	localparam int TWL_TYP_MS    = 16;
	localparam int TWC_CYCLES = TWC_TYP_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TEC_CYCLES = TEC_TYP_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TWL_CYCLES = TWL_TYP_MS * 1000000 / CLK_PERIOD_NS;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_OPC  = 6'b000010,
		ST_ADDR = 6'b000100,
		ST_DATA = 6'b001000,
		ST_READ = 6'b010000,
		ST_DONE = 6'b100000
	} secif_state_t;

	typedef enum logic [4:0] {
		PG_NONE      = 5'b00001,
		PG_ERASE     = 5'b00010,
		PG_WRITE     = 5'b00100,
		PG_ERASE_ALL = 5'b01000,
		PG_WRITE_ALL = 5'b10000
	} secif_prog_t;

endpackage

// ===== src/secif_top.sv
// ----------------------------------------------------------------
// serial eeprom command interface: decoder, array, programming
// ----------------------------------------------------------------
// pins are asynchronous and sampled by core_clk_i; the testbench
// resolves the data-out wire from do_o and do_oe_o
`timescale 1ns/10ps

module secif_top #(
	parameter int KBIT    = 4,
	parameter int TWC_CYC = secif_pkg::TWC_CYCLES,
	parameter int TEC_CYC = secif_pkg::TEC_CYCLES,
	parameter int TWL_CYC = secif_pkg::TWL_CYCLES
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  reset_n_i,
	input  wire secif_pkg::secif_pins_t serial_i,
	output logic                       do_o,
	output logic                       do_oe_o,
	output logic                       selected_o
);
	import secif_pkg::*;

	localparam int BYTES = KBIT * BYTES_PER_KBIT;
	localparam int BAW   = $clog2(BYTES);
	localparam int AF16  = (KBIT == 1) ? AFIELD_1K : AFIELD_2K4K;
	localparam int PCW   = $clog2(TWL_CYC + 1);

	// ----------------------------------------------------------------
	// pin synchroniser and edge finder
	// ----------------------------------------------------------------
	secif_pins_t s1_r, s2_r, s3_r, pin_r;
	logic        sclk_prev_r, cs_prev_r;
	logic        sclk_rise, cs_fall;

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			s1_r        <= '0;
			s2_r        <= '0;
			s3_r        <= '0;
			pin_r       <= '0;
			sclk_prev_r <= 1'b0;
			cs_prev_r   <= 1'b0;
		end else begin
			s1_r        <= serial_i;
			s2_r        <= s1_r;
			s3_r        <= s2_r;
			pin_r       <= secif_pins_t'((~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & pin_r));
			sclk_prev_r <= pin_r.sclk;
			cs_prev_r   <= pin_r.cs;
		end
	end

	assign sclk_rise = pin_r.cs & pin_r.sclk & ~sclk_prev_r;
	assign cs_fall   = cs_prev_r & ~pin_r.cs;

	// ----------------------------------------------------------------
	// frame decoder
	// ----------------------------------------------------------------
	secif_state_t      st_r;
	secif_prog_t       pend_r;
	logic              word_mode_r, en_r, busy_r, armed_r;
	logic [1:0]        op_r;
	logic [4:0]        cnt_r;
	logic [7:0]        af_r;
	logic [15:0]       dat_r, rd_sr_r;
	logic [BAW-1:0]    base_r, rd_base_r;
	logic [8:0]        field;
	logic [1:0]        ext;
	logic [4:0]        alast, dlast;
	logic [BAW-1:0]    fbase, rd_next;
	logic              start_ok;
	logic [7:0]        mem_r [BYTES];

	function automatic logic [15:0] rd_word(input logic [BAW-1:0] b);
		rd_word = word_mode_r ? {mem_r[b | BAW'(1)], mem_r[b]} : {mem_r[b], 8'h00};
	endfunction

	// field widths per size and organisation
	// 2 kbit field carries a leading don't-care bit
	// 4 kbit field uses all its bits
	assign alast = word_mode_r ? 5'(AF16 - 1) : 5'(AF16);
	assign dlast = word_mode_r ? 5'h0F : 5'h07;
	assign field = {af_r, pin_r.di};
	// top two field bits select the extended command
	assign ext   = 2'(field >> (alast - 5'h01));
	// leading bit dropped by taking only the array's address bits
	assign fbase = word_mode_r ? {field[BAW-2:0], 1'b0} : field[BAW-1:0];
	assign rd_next = rd_base_r + (word_mode_r ? BAW'(2) : BAW'(1));
	// no new frame while the array is busy
	assign start_ok = ~busy_r;

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i || !pin_r.cs) begin
			// deselect holds the decoder in reset
			st_r  <= ST_IDLE;
			cnt_r <= '0;
		end else if (sclk_rise) begin
			unique case (st_r)
				ST_IDLE: begin
					// anything else leaves the decoder idle
					if (pin_r.di && start_ok) begin
						st_r  <= ST_OPC;
						cnt_r <= OPC_LAST;
					end
				end
				ST_OPC: begin
					cnt_r <= cnt_r - 5'h01;
					if (cnt_r == '0) begin
						st_r  <= ST_ADDR;
						cnt_r <= alast;
					end
				end
				ST_ADDR: begin
					cnt_r <= cnt_r - 5'h01;
					if (cnt_r == '0) begin
						// opcode decides the rest of the frame
						cnt_r <= dlast;
						if (op_r == OP_READ)
							st_r <= ST_READ;
						else if (op_r == OP_WRITE || (op_r == OP_EXT && ext == EXT_WRITE_ALL))
							st_r <= ST_DATA;
						else
							st_r <= ST_DONE;
					end
				end
				ST_DATA: begin
					cnt_r <= cnt_r - 5'h01;
					if (cnt_r == '0)
						st_r <= ST_DONE;
				end
				ST_READ: cnt_r <= (cnt_r == '0) ? dlast : cnt_r - 5'h01;
				ST_DONE: st_r <= ST_DONE;
			endcase
		end
	end

	// shift in opcode, address and data bits
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			op_r  <= '0;
			af_r  <= '0;
			dat_r <= '0;
			word_mode_r <= 1'b0;
		end else if (sclk_rise) begin
			if (st_r == ST_IDLE) begin
				af_r  <= '0;
				// organisation taken at the start marker bit
				word_mode_r <= pin_r.organization_select;
			end
			if (st_r == ST_OPC)
				op_r <= {op_r[0], pin_r.di};
			if (st_r == ST_ADDR)
				af_r <= field[7:0];
			if (st_r == ST_DATA)
				dat_r <= {dat_r[14:0], pin_r.di};
		end
	end

	// ----------------------------------------------------------------
	// enable latch and pending operation
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			en_r   <= 1'b0;
			pend_r <= PG_NONE;
			base_r <= '0;
		end else if (!pin_r.cs) begin
			pend_r <= PG_NONE;
		end else if (sclk_rise && st_r == ST_ADDR && cnt_r == '0) begin
			base_r <= fbase;
			// commands act only once the field is complete
			if (op_r == OP_ERASE)
				pend_r <= PG_ERASE;
			if (op_r == OP_EXT) begin
				// enable and disable drive the latch
				if (ext == EXT_EN)
					en_r <= 1'b1;
				if (ext == EXT_DIS)
					en_r <= 1'b0;
				if (ext == EXT_ERASE_ALL)
					pend_r <= PG_ERASE_ALL;
			end
		end else if (sclk_rise && st_r == ST_DATA && cnt_r == '0) begin
			pend_r <= (op_r == OP_WRITE) ? PG_WRITE : PG_WRITE_ALL;
		end
	end

	// ----------------------------------------------------------------
	// self-timed programming and array
	// ----------------------------------------------------------------
	logic           go;
	logic [PCW-1:0] pcnt_r;
	logic [15:0]    wdat;

	// only while the enable latch is set
	assign go   = cs_fall && pend_r != PG_NONE && en_r && !busy_r;
	assign wdat = word_mode_r ? dat_r : {dat_r[7:0], dat_r[7:0]};

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			busy_r <= 1'b0;
			pcnt_r <= '0;
		end else if (go) begin
			busy_r <= 1'b1;
			unique case (pend_r)
				PG_ERASE_ALL: pcnt_r <= PCW'(TEC_CYC - 1);
				PG_WRITE_ALL: pcnt_r <= PCW'(TWL_CYC - 1);
				default: pcnt_r <= PCW'(TWC_CYC - 1);
			endcase
		end else if (busy_r) begin
			pcnt_r <= pcnt_r - PCW'(1);
			if (pcnt_r == '0)
				busy_r <= 1'b0;
		end
	end

	// array lives in flip-flops; no reset, contents are kept
	generate
		for (genvar i = 0; i < BYTES; i++) begin : g_cell
			localparam logic [BAW-1:0] IDX = BAW'(i);
			always_ff @(posedge core_clk_i) begin
				if (go) begin
					if (pend_r == PG_ERASE_ALL)
						mem_r[i] <= 8'hFF;
					else if (pend_r == PG_WRITE_ALL)
						mem_r[i] <= (word_mode_r && IDX[0]) ? wdat[15:8] : wdat[7:0];
					else if (IDX == base_r)
						mem_r[i] <= (pend_r == PG_ERASE) ? 8'hFF : wdat[7:0];
					else if (word_mode_r && IDX == (base_r | BAW'(1)))
						mem_r[i] <= (pend_r == PG_ERASE) ? 8'hFF : wdat[15:8];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// data out, status arming and standby
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i)
			armed_r <= 1'b0;
		else if (go)
			armed_r <= 1'b1;
		else if (cs_fall || (sclk_rise && st_r == ST_IDLE && pin_r.di && start_ok))
			armed_r <= 1'b0;
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			do_o      <= 1'b1;
			do_oe_o   <= 1'b0;
			rd_sr_r   <= '0;
			rd_base_r <= '0;
		end else if (!pin_r.cs) begin
			do_oe_o <= 1'b0;
		end else if (sclk_rise && st_r == ST_ADDR && cnt_r == '0 && op_r == OP_READ) begin
			// dummy zero ahead of the word
			do_oe_o   <= 1'b1;
			do_o      <= 1'b0;
			rd_sr_r   <= rd_word(fbase);
			rd_base_r <= fbase;
		end else if (st_r == ST_READ) begin
			do_oe_o <= 1'b1;
			// next bit right after the rising edge
			if (sclk_rise && cnt_r == '0) begin
				// last bit out, next word preloaded, wraps at the end
				do_o      <= rd_sr_r[15];
				rd_base_r <= rd_next;
				rd_sr_r   <= rd_word(rd_next);
			end else if (sclk_rise) begin
				do_o    <= rd_sr_r[15];
				rd_sr_r <= rd_sr_r << 1;
			end
		end else if (armed_r) begin
			// low while busy, high when ready
			// only programming commands arm the status
			do_oe_o <= 1'b1;
			do_o    <= ~busy_r;
		end else begin
			do_oe_o <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i)
			selected_o <= 1'b0;
		else
			selected_o <= pin_r.cs;
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	chk_start_detect: assert property (st_r == ST_IDLE && sclk_rise && pin_r.di && start_ok
		|=> st_r == ST_OPC) else $error("start bit missed");
	chk_idle_quiet: assert property (st_r == ST_IDLE && sclk_rise && !pin_r.di
		|=> st_r == ST_IDLE && !go) else $error("activity without start bit");
	chk_done_hold: assert property (st_r == ST_DONE && pin_r.cs
		|=> st_r == ST_DONE) else $error("left done state while selected");
	chk_float_desel: assert property (!pin_r.cs |=> !do_oe_o)
		else $error("data out driven while deselected");
	chk_status_level: assert property (armed_r && pin_r.cs && st_r != ST_READ
		|=> do_oe_o && do_o == !$past(busy_r)) else $error("wrong ready/busy level");
	chk_quiet_cmd: assert property (st_r == ST_DONE && !armed_r && pin_r.cs
		|=> !do_oe_o) else $error("data out driven after enable/disable");
	chk_dummy_zero: assert property ($rose(st_r == ST_READ) |-> do_oe_o && !do_o)
		else $error("no dummy zero before read data");
	chk_read_stable: assert property (st_r == ST_READ && !sclk_rise && pin_r.cs
		##1 st_r == ST_READ |-> $stable(do_o)) else $error("read bit moved off edge");
	chk_latch_gate: assert property (cs_fall && pend_r != PG_NONE && !en_r
		|=> !busy_r ##1 !busy_r) else $error("programming while disabled");
	chk_prog_start: assert property (go |=> busy_r && armed_r)
		else $error("programming not started on deselect");

	cov_read: cover property (st_r == ST_READ && sclk_rise && cnt_r == '0);
	cov_write: cover property (go && pend_r == PG_WRITE);
	cov_write_all: cover property (go && pend_r == PG_WRITE_ALL);
	cov_ready: cover property (armed_r && $fell(busy_r));

endmodule

// ===== verification/secif_host_model.sv
// ----------------------------------------------------------------
// host model: drives chip select, serial clock and data in
// ----------------------------------------------------------------
// assumes the bench resolves data out with a pull-up into do_line_i
`timescale 1ns/10ps

module secif_host_model (
	input  wire logic             core_clk_i,
	input  wire logic             word_mode_i,
	input  wire logic             do_line_i,
	output secif_pkg::secif_pins_t pins_o
);
	import secif_pkg::*;

	logic cs_r = 1'b0;
	logic sclk_r = 1'b0;
	logic di_r = 1'b0;

	assign pins_o = {cs_r, sclk_r, di_r, word_mode_i};

	task automatic select();
		@(negedge core_clk_i);
		cs_r = 1'b1;
		repeat (12) @(negedge core_clk_i);
	endtask

	// cs drop, held low over 250 ns
	task automatic deselect();
		@(negedge core_clk_i);
		cs_r = 1'b0;
		sclk_r = 1'b0;
		// released data in shows the inverse
		di_r = ~di_r;
		repeat (70) @(negedge core_clk_i);
	endtask

	// bit presented for the rise, data out sampled before it
	task automatic bit_xfer(input logic d, output logic q);
		@(negedge core_clk_i);
		di_r = d;
		repeat (9) @(negedge core_clk_i);
		q = do_line_i;
		sclk_r = 1'b1;
		repeat (10) @(negedge core_clk_i);
		sclk_r = 1'b0;
	endtask

	task automatic send(input logic [31:0] v, input int n);
		logic q;
		for (int i = n - 1; i >= 0; i--) begin
			bit_xfer(v[i], q);
		end
	endtask

	task automatic recv(input int n, output logic [31:0] v);
		logic q;
		v = '0;
		for (int i = 0; i < n; i++) begin
			// host lets go of data in after the address
			bit_xfer(~di_r, q);
			v = {v[30:0], q};
		end
	endtask
endmodule

// ===== verification/test_serial_eeprom_cmd_interface.sv
// ----------------------------------------------------------------
// testbench: random and corner command frames, checked on data out
// ----------------------------------------------------------------
// assumes a 1 kbit array and shortened programming times
`timescale 1ns/10ps

module test_serial_eeprom_cmd_interface;
	import secif_pkg::*;

	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        word_mode = 1'b1;
	secif_pins_t pins;
	logic        do_val;
	logic        do_oe;
	logic        selected;
	wire         do_line = do_oe ? do_val : 1'b1;
	logic [7:0]  mem [128];
	logic        en = 1'b0;
	int          mismatches = 0;
	int          n_compared = 0;

	always #2 core_clk = ~core_clk;

	secif_top #(.KBIT(1), .TWC_CYC(200), .TEC_CYC(300), .TWL_CYC(400)) u_secif_top (
		.core_clk_i (core_clk),
		.reset_n_i  (reset_n),
		.serial_i   (pins),
		.do_o       (do_val),
		.do_oe_o    (do_oe),
		.selected_o (selected)
	);

	secif_host_model u_h (
		.core_clk_i (core_clk),
		.word_mode_i (word_mode),
		.do_line_i  (do_line),
		.pins_o     (pins)
	);

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic test_end(input string name);
		$display("test %s done, %0d compared", name, n_compared);
	endtask

	function automatic int abits(input logic o);
		return AFIELD_1K + (o ? 0 : 1);
	endfunction

	function automatic int dbits(input logic o);
		return o ? 16 : 8;
	endfunction

	function automatic logic [15:0] word_at(input int w, input logic o);
		w = w % (o ? 64 : 128);
		return o ? {mem[2 * w + 1], mem[2 * w]} : {8'h00, mem[w]};
	endfunction

	function automatic int xa(input logic [1:0] ex);
		return (int'(ex) << (abits(word_mode) - 2)) | $urandom_range(15);
	endfunction

	task automatic upd(input logic [1:0] op, input logic [1:0] ex, input int a, input logic [15:0] d);
		logic [15:0] v;
		v = (op == OP_ERASE || ex == EXT_ERASE_ALL) ? 16'hFFFF : d;
		if (op == OP_EXT) begin
			for (int i = 0; i < 128; i++) begin
				mem[i] = (word_mode && i[0]) ? v[15:8] : v[7:0];
			end
		end else if (word_mode) begin
			mem[2 * a] = v[7:0];
			mem[2 * a + 1] = v[15:8];
		end else begin
			mem[a] = v[7:0];
		end
	endtask

	task automatic cmd(input logic [1:0] op, input int a, input logic [15:0] d);
		logic [1:0] ex;
		logic       prog;
		int         k;
		ex = 2'(a >> (abits(word_mode) - 2));
		prog = (op != OP_EXT) ? (op != OP_READ) : (ex == EXT_ERASE_ALL || ex == EXT_WRITE_ALL);
		u_h.select();
		chk(16'(selected), 16'h1, "select");
		u_h.send({29'h0, 1'b1, op}, 3 + $urandom_range(3));
		u_h.send(32'(a), abits(word_mode));
		if (op == OP_WRITE || (op == OP_EXT && ex == EXT_WRITE_ALL)) begin
			u_h.send(32'(d), dbits(word_mode));
		end
		chk(16'(do_oe), 16'h0, "float in frame");
		u_h.deselect();
		chk(16'(selected), 16'h0, "deselect");
		u_h.select();
		chk(16'(do_oe), 16'(prog && en), "status offered");
		if (prog && en) begin
			chk(16'(do_line), 16'h0, "busy");
			k = 0;
			while (do_line !== 1'b1 && k < 2000) begin
				@(negedge core_clk);
				k++;
			end
			chk(16'(do_line), 16'h1, "ready");
			upd(op, (op == OP_EXT) ? ex : 2'h0, a, d);
		end
		if (op == OP_EXT && ex == EXT_EN) en = 1'b1;
		if (op == OP_EXT && ex == EXT_DIS) en = 1'b0;
		u_h.deselect();
	endtask

	task automatic rd(input int a, input int nw);
		logic [31:0] v;
		u_h.select();
		u_h.send({29'h0, 1'b1, OP_READ}, 3);
		u_h.send(32'(a), abits(word_mode));
		u_h.recv(1, v);
		chk(v[15:0], 16'h0, "dummy zero");
		for (int i = 0; i < nw; i++) begin
			u_h.recv(dbits(word_mode), v);
			chk(v[15:0], word_at(a + i, word_mode), "read word");
		end
		u_h.deselect();
		chk(16'(do_oe), 16'h0, "float after read");
	endtask

	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		int a;
		void'($urandom(32'hcc1c26c7));
		repeat (5) @(negedge core_clk);
		reset_n = 1'b1;
		repeat (5) @(negedge core_clk);
		chk(16'(do_oe), 16'h0, "idle float");
		cmd(OP_WRITE, 5, 16'h1234);
		test_end("locked");
		cmd(OP_EXT, xa(EXT_EN), 16'h0000);
		cmd(OP_EXT, xa(EXT_ERASE_ALL), 16'h0000);
		rd(0, 3);
		test_end("erase all");
		for (int t = 0; t < 8; t++) begin
			word_mode = t[0];
			a = $urandom_range(word_mode ? 63 : 127);
			cmd(OP_WRITE, a, 16'($urandom));
			cmd(OP_WRITE, (a + 1) % (word_mode ? 64 : 128), 16'($urandom));
			rd(a, 2);
		end
		word_mode = 1'b0;
		rd(126, 4);
		word_mode = 1'b1;
		cmd(OP_ERASE, 63, 16'h0000);
		rd(62, 3);
		test_end("random and wrap");
		cmd(OP_EXT, xa(EXT_WRITE_ALL), 16'($urandom));
		rd(62, 3);
		cmd(OP_EXT, xa(EXT_DIS), 16'h0000);
		cmd(OP_WRITE, 3, 16'h5A5A);
		cmd(OP_ERASE, 4, 16'h0000);
		rd(3, 2);
		test_end("write all and disable");
		cmd(OP_EXT, xa(EXT_EN), 16'h0000);
		u_h.select();
		u_h.send({29'h0, 1'b1, OP_WRITE}, 3);
		u_h.send(32'h9, abits(word_mode));
		u_h.send(32'h15, 5);
		u_h.deselect();
		u_h.select();
		chk(16'(do_oe), 16'h0, "cut frame dropped");
		u_h.deselect();
		rd(9, 1);
		test_end("short frame");
		finish_test();
	end

	initial begin
		repeat (60000) @(posedge core_clk);
		mismatches++;
		$display("Error at %0t: watchdog expired", $time);
		finish_test();
	end
endmodule
